// *** shared/uche_pkg.sv ***
// Package for the uncore cache and home-logic event selector.
// Assumes one 100 MHz uncore clock shared by the selector, APB and all event sources.
package uche_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int          APB_AW        = 12;
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_CNT_LO    = 12'h004;
  localparam logic [11:0] OFS_CNT_HI    = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00C;
  localparam int          CTRL_CODE_LSB = 0;
  localparam int          CTRL_MASK_LSB = 8;
  localparam int          CTRL_EN_BIT   = 16;
  localparam int          CTRL_CLR_BIT  = 17;
  localparam int          STAT_SEL_BIT  = 0;
  localparam int          STAT_ERR_BIT  = 1;
  localparam int          STAT_FULL_LSB = 2;
  localparam int          STAT_BUSY_LSB = 5;
  localparam logic [7:0]  CODE_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST      = 8'h00;
  localparam int          CNT_WIDTH_DEF = 48;

  // ----------------------------------------------------------------
  // Event codes and unit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] EVC_FILL     = 8'h0A;
  localparam logic [7:0] EVC_VICTIM   = 8'h0B;
  localparam logic [7:0] EVC_HOME_REQ = 8'h20;
  localparam logic [7:0] EVC_TRK_FULL = 8'h21;
  localparam logic [7:0] EVC_TRK_BUSY = 8'h22;
  localparam int         FILL_BITS    = 4;
  localparam int         VICTIM_BITS  = 5;
  localparam int         REQ_BITS     = 6;
  localparam int         TRK_BITS     = 3;
  localparam int         STATE_MOD    = 0;

  typedef enum logic [2:0] {
    CL_NONE, CL_FILL, CL_VICTIM, CL_REQ, CL_FULL, CL_BUSY
  } uche_class_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Fill and victim states are one-hot; every vector has the bit order of its unit mask:
  // fill M,E,S,F; victim M,E,S,I,F; requests io_hub rd/wr, remote rd/wr,
  // local rd/wr; trackers io_hub, remote, local.
  typedef struct packed {
    logic                   fillValid;
    logic [FILL_BITS-1:0]   fillState;
    logic                   fillSnoopOwn;
    logic                   victimValid;
    logic [VICTIM_BITS-1:0] victimState;
    logic                   victimRemote;
  } uche_cache_ev_t;

  typedef struct packed {
    logic [REQ_BITS-1:0] req;
    logic [TRK_BITS-1:0] full;
    logic [TRK_BITS-1:0] busy;
  } uche_home_ev_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } uche_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } uche_apb_rsp_t;

endpackage

// *** design/uche_counter.sv ***
// Wrapping event counter with a synchronous clear.
// Assumes the increment is already gated by the event selection.
`timescale 1ns/100ps
module uche_counter #(
  parameter int WIDTH = 48
) (
  // Clock and control
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             clear,
  // Count
  input  wire logic [2:0]       incAmt,
  output logic      [WIDTH-1:0] count_ff
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH < 8 || WIDTH > 64) begin : g_chk
    $error("Counter width must lie between 8 and 64.");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // The counter wraps silently; no block in the design flags an overflow.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (clkEn) begin
      if (clear) begin
        count_ff <= '0;
      end else begin
        count_ff <= count_ff + WIDTH'(incAmt);
      end
    end
  end

endmodule

// *** design/uche_event_select.sv ***
// Event selector and counter for last-level cache fills, victims and home-logic activity.
// Assumes event sources and APB share ref_clk, so event inputs are not synchronised.
//
// Notes on behaviour
// - Code 0AH, mask 01H: count each cache line filled in modified state.
// - Fill code: mask 02H counts exclusive fills, mask 04H counts shared fills.
// - Fill code: mask 08H counts forward fills, mask 0FH counts fills in any state.
// - Modified fills are legal only when forwarded by a snoop read-invalidate-own.
// - Code 0BH, mask 01H counts modified victims; each is written back home.
// - Victim code: mask 02H counts exclusive victims, mask 04H shared victims.
// - Victim code: mask 08H counts invalid victims, mask 10H forward victims.
// - Victim code: mask 1FH counts every victim whatever its state.
// - Code 20H: mask 01H counts io_hub reads, 02H io_hub writes.
// - Request code: mask 04H counts remote reads, 08H remote writes.
// - Request code: mask 10H counts local reads, 20H local writes.
// - Code 21H counts cycles the chosen tracker is full; 01H/02H/04H pick tracker.
// - Code 22H counts cycles the chosen tracker is busy, same tracker mask.
`timescale 1ns/100ps
module uche_event_select #(
  parameter int CNT_WIDTH = uche_pkg::CNT_WIDTH_DEF
) (
  // Clock, reset and clock enable
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clkEn,
  // APB register port
  input  wire uche_pkg::uche_apb_req_t apbReq,
  output uche_pkg::uche_apb_rsp_t      apbRsp,
  // Event sources
  input  wire uche_pkg::uche_cache_ev_t cacheEv,
  input  wire uche_pkg::uche_home_ev_t  homeEv,
  // Modified victim write-back notices
  output logic                         wbLocal,
  output logic                         wbRemote
);
  import uche_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_WIDTH < 33 || CNT_WIDTH > 64) begin : g_chk
    $error("CNT_WIDTH must lie between 33 and 64.");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic uche_class_t classOf(input logic [7:0] code);
    uche_class_t cl;
    cl = CL_NONE;
    case (code)
      EVC_FILL:     cl = CL_FILL;
      EVC_VICTIM:   cl = CL_VICTIM;
      EVC_HOME_REQ: cl = CL_REQ;
      EVC_TRK_FULL: cl = CL_FULL;
      EVC_TRK_BUSY: cl = CL_BUSY;
      default:      cl = CL_NONE;
    endcase
    return cl;
  endfunction

  function automatic logic [2:0] popCount(input logic [REQ_BITS-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < REQ_BITS; i++) begin
      n = n + 3'(v[i]);
    end
    return n;
  endfunction

  function automatic logic isMapped(input logic [APB_AW-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_CNT_LO) || (a == OFS_CNT_HI)
        || (a == OFS_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]           code_ff;
  logic [7:0]           umask_ff;
  logic                 enable_ff;
  logic                 modErr_ff;
  logic                 wbLocal_ff;
  logic                 wbRemote_ff;
  uche_apb_rsp_t        apbRsp_ff;
  uche_apb_rsp_t        nxt_apbRsp;
  logic [CNT_WIDTH-1:0] count;
  logic [63:0]          count64;
  uche_class_t          evClass;
  logic                 apbSetup;
  logic                 apbDone;
  logic                 wrCtrl;
  logic                 wrStatus;
  logic                 cntClear;
  logic                 fillLegal;
  logic                 fillHit;
  logic                 victimHit;
  logic [2:0]           reqHits;
  logic                 fullHit;
  logic                 busyHit;
  logic                 modErrSet;
  logic [2:0]           nxt_inc;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbDone  = apbReq.psel && apbReq.penable && apbRsp_ff.pready;
  assign wrCtrl   = apbDone && apbReq.pwrite && (apbReq.paddr == OFS_CTRL);
  assign wrStatus = apbDone && apbReq.pwrite && (apbReq.paddr == OFS_STATUS);
  assign cntClear = wrCtrl && apbReq.pwdata[CTRL_CLR_BIT];
  assign count64  = 64'(count);

  // ----------------------------------------------------------------
  // Event matching
  // ----------------------------------------------------------------
  assign evClass = classOf(code_ff);

  // A modified fill that did not come from a snoop read-invalidate-own is
  // dropped and flagged rather than counted, so a broken source cannot
  // inflate the modified count.
  assign fillLegal = !(cacheEv.fillState[STATE_MOD] && !cacheEv.fillSnoopOwn);
  assign modErrSet = cacheEv.fillValid && !fillLegal;
  assign fillHit   = cacheEv.fillValid && fillLegal
                  && |(cacheEv.fillState & umask_ff[FILL_BITS-1:0]);
  assign victimHit = cacheEv.victimValid
                  && |(cacheEv.victimState & umask_ff[VICTIM_BITS-1:0]);
  assign reqHits   = popCount(homeEv.req & umask_ff[REQ_BITS-1:0]);
  assign fullHit   = |(homeEv.full & umask_ff[TRK_BITS-1:0]);
  assign busyHit   = |(homeEv.busy & umask_ff[TRK_BITS-1:0]);

  always_comb begin
    nxt_inc = 3'h0;
    if (enable_ff) begin
      case (evClass)
        CL_FILL:   nxt_inc = {2'h0, fillHit};
        CL_VICTIM: nxt_inc = {2'h0, victimHit};
        CL_REQ:    nxt_inc = reqHits;
        CL_FULL:   nxt_inc = {2'h0, fullHit};
        CL_BUSY:   nxt_inc = {2'h0, busyHit};
        default:   nxt_inc = 3'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  uche_counter #(
    .WIDTH    (CNT_WIDTH)
  ) u_counter (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .clear    (cntClear),
    .incAmt   (nxt_inc),
    .count_ff (count)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      code_ff   <= CODE_RST;
      umask_ff  <= MASK_RST;
      enable_ff <= 1'b0;
    end else if (clkEn && wrCtrl) begin
      code_ff   <= apbReq.pwdata[CTRL_CODE_LSB +: 8];
      umask_ff  <= apbReq.pwdata[CTRL_MASK_LSB +: 8];
      enable_ff <= apbReq.pwdata[CTRL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sticky illegal-fill flag
  // ----------------------------------------------------------------
  // A new illegal fill in the clearing cycle keeps the flag set.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      modErr_ff <= 1'b0;
    end else if (clkEn) begin
      modErr_ff <= modErrSet
                || (modErr_ff && !(wrStatus && apbReq.pwdata[STAT_ERR_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Write-back notices
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wbLocal_ff  <= 1'b0;
      wbRemote_ff <= 1'b0;
    end else if (clkEn) begin
      wbLocal_ff  <= cacheEv.victimValid && cacheEv.victimState[STATE_MOD]
                  && !cacheEv.victimRemote;
      wbRemote_ff <= cacheEv.victimValid && cacheEv.victimState[STATE_MOD]
                  && cacheEv.victimRemote;
    end
  end

  assign wbLocal  = wbLocal_ff;
  assign wbRemote = wbRemote_ff;

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle. The two count halves are read
  // in separate transfers, so software must re-read the high half to catch
  // a carry between them.
  always_comb begin
    nxt_apbRsp         = '0;
    nxt_apbRsp.pready  = apbSetup;
    nxt_apbRsp.pslverr = apbSetup && !isMapped(apbReq.paddr);
    if (apbSetup && !apbReq.pwrite) begin
      case (apbReq.paddr)
        OFS_CTRL: begin
          nxt_apbRsp.prdata[CTRL_CODE_LSB +: 8] = code_ff;
          nxt_apbRsp.prdata[CTRL_MASK_LSB +: 8] = umask_ff;
          nxt_apbRsp.prdata[CTRL_EN_BIT]        = enable_ff;
        end
        OFS_CNT_LO: begin
          nxt_apbRsp.prdata = count64[31:0];
        end
        OFS_CNT_HI: begin
          nxt_apbRsp.prdata = count64[63:32];
        end
        OFS_STATUS: begin
          nxt_apbRsp.prdata[STAT_SEL_BIT]             = (evClass != CL_NONE);
          nxt_apbRsp.prdata[STAT_ERR_BIT]             = modErr_ff;
          nxt_apbRsp.prdata[STAT_FULL_LSB +: TRK_BITS] = homeEv.full;
          nxt_apbRsp.prdata[STAT_BUSY_LSB +: TRK_BITS] = homeEv.busy;
        end
        default: begin
          nxt_apbRsp.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      apbRsp_ff <= '0;
    end else if (clkEn) begin
      apbRsp_ff <= nxt_apbRsp;
    end
  end

  assign apbRsp = apbRsp_ff;

endmodule

// *** dv/uche_event_select_props.sv ***
// Port checker for the event selector.
// Assumes it is bound to the selector; cycles frozen by a low clkEn are left out of the write-back and ready checks.
`timescale 1ns/100ps
module uche_event_select_props #(
  parameter int CNT_WIDTH = 48
) (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     clkEn,
  // Register bus
  input wire uche_pkg::uche_apb_req_t  apbReq,
  input wire uche_pkg::uche_apb_rsp_t  apbRsp,
  // Events and notices
  input wire uche_pkg::uche_cache_ev_t cacheEv,
  input wire uche_pkg::uche_home_ev_t  homeEv,
  input wire logic                     wbLocal,
  input wire logic                     wbRemote
);
  import uche_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic modVic = cacheEv.victimValid && cacheEv.victimState[0];
  wire logic rdStat = apbRsp.pready && !apbReq.pwrite && apbReq.paddr == OFS_STATUS;

  property p_wb_local;
    $past(rst_n) && $past(clkEn) && $past(modVic) && !$past(cacheEv.victimRemote) |-> wbLocal;
  endproperty
  a_wb_local: assert property (p_wb_local) else $error("no local write-back");
  property p_wb_remote;
    $past(rst_n) && $past(clkEn) && $past(modVic) && $past(cacheEv.victimRemote) |-> wbRemote;
  endproperty
  a_wb_remote: assert property (p_wb_remote) else $error("no remote write-back");
  property p_wb_cause;
    $past(clkEn) && (wbLocal || wbRemote) |-> $past(modVic) && !(wbLocal && wbRemote);
  endproperty
  a_wb_cause: assert property (p_wb_cause) else $error("stray write-back");
  property p_full_live;
    rdStat |-> apbRsp.prdata[4:2] == $past(homeEv.full);
  endproperty
  a_full_live: assert property (p_full_live) else $error("full status wrong");
  property p_busy_live;
    rdStat |-> apbRsp.prdata[7:5] == $past(homeEv.busy);
  endproperty
  a_busy_live: assert property (p_busy_live) else $error("busy status wrong");
  property p_rdy_setup;
    apbReq.psel && !apbReq.penable && clkEn |=> apbRsp.pready;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  property p_rdy_one;
    apbRsp.pready && clkEn |=> !apbRsp.pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_err_map;
    apbRsp.pready && apbReq.paddr > OFS_STATUS |-> apbRsp.pslverr && apbRsp.prdata == 32'h0;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_quiet;
    !apbRsp.pready |-> apbRsp.prdata == 32'h0 && !apbRsp.pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("idle response not zero");
endmodule

bind uche_event_select uche_event_select_props #(.CNT_WIDTH(CNT_WIDTH)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
  .cacheEv(cacheEv), .homeEv(homeEv), .wbLocal(wbLocal), .wbRemote(wbRemote)
);

// *** dv/uche_src_model.sv ***
// Random cache and home-logic event source.
// Assumes the bench raises run only while it wants traffic.
`timescale 1ns/100ps
module uche_src_model (
  // Clock and control
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               run,
  input  wire logic               badFill,
  // Events
  output uche_pkg::uche_cache_ev_t cacheEv,
  output uche_pkg::uche_home_ev_t  homeEv
);
  import uche_pkg::*;
  logic [31:0] r;
  // Idle sources drop to zero, the true quiet level of pulses and levels.
  always @(posedge ref_clk) begin
    r = $urandom;
    if (!rst_n || !run) begin
      cacheEv <= '0;
      homeEv  <= '0;
    end else begin
      cacheEv.fillValid    <= r[0];
      cacheEv.fillState    <= badFill ? 4'h1 : 4'h1 << r[2:1];
      cacheEv.fillSnoopOwn <= !badFill;
      cacheEv.victimValid  <= r[3];
      cacheEv.victimState  <= 5'h01 << (r[6:4] % 5);
      cacheEv.victimRemote <= r[7];
      homeEv.req           <= r[13:8];
      homeEv.full          <= r[16:14] & r[19:17];
      homeEv.busy          <= r[22:20] | (r[16:14] & r[19:17]);
    end
  end
endmodule

// *** dv/uche_event_select_tb_top.sv ***
// Self-checking bench for the event selector with a random event source.
// Assumes clkEn drops only between bus transfers; counts are read while the source is quiet.
`timescale 1ns/100ps
module uche_event_select_tb_top;
  import uche_pkg::*;
  localparam int CW = 40;
  logic           ref_clk, rst_n, clkEn, run, badFill, err, known;
  uche_apb_req_t  req;
  uche_apb_rsp_t  rsp;
  uche_cache_ev_t cEv;
  uche_home_ev_t  hEv;
  logic [31:0]    ctrl_ff, q, w;
  logic [63:0]    expCnt_ff;
  int             failCount, nChecks, i;
  logic [15:0]    tbl [28] = '{16'h0A01, 16'h0A02, 16'h0A04, 16'h0A08, 16'h0A0F, 16'h0A05,
    16'h0B01, 16'h0B02, 16'h0B04, 16'h0B08, 16'h0B10, 16'h0B1F, 16'h2001, 16'h2002,
    16'h2004, 16'h2008, 16'h2010, 16'h2020, 16'h203F, 16'h2101, 16'h2102, 16'h2104,
    16'h2106, 16'h2201, 16'h2202, 16'h2204, 16'h22F9, 16'h0C01};

  uche_event_select #(.CNT_WIDTH(CW)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .apbReq(req), .apbRsp(rsp), .cacheEv(cEv), .homeEv(hEv), .wbLocal(), .wbRemote());
  uche_src_model i_src (.ref_clk(ref_clk), .rst_n(rst_n), .run(run), .badFill(badFill),
    .cacheEv(cEv), .homeEv(hEv));

  // ----------------------------------------------------------------
  // Reference count
  // ----------------------------------------------------------------
  function automatic logic [2:0] incOf(logic [31:0] c, uche_cache_ev_t e, uche_home_ev_t h);
    if (!c[16]) return 3'h0;
    case (c[7:0])
      EVC_FILL:     return 3'(e.fillValid && !(e.fillState[0] && !e.fillSnoopOwn)
                              && |(e.fillState & c[11:8]));
      EVC_VICTIM:   return 3'(e.victimValid && |(e.victimState & c[12:8]));
      EVC_HOME_REQ: return 3'($countones(h.req & c[13:8]));
      EVC_TRK_FULL: return 3'(|(h.full & c[10:8]));
      EVC_TRK_BUSY: return 3'(|(h.busy & c[10:8]));
      default:      return 3'h0;
    endcase
  endfunction

  wire logic ctrlWr = req.psel && req.penable && req.pwrite && rsp.pready
                      && req.paddr == OFS_CTRL;
  // Uses the old control word at the write edge, as the counter does.
  // A low clock enable loses the events of that cycle, so the model skips them too.
  always @(posedge ref_clk) begin
    if (!rst_n) ctrl_ff <= 32'h0;
    else if (clkEn && ctrlWr) ctrl_ff <= req.pwdata & 32'h0001FFFF;
    if (!rst_n || (clkEn && ctrlWr && req.pwdata[17])) expCnt_ff <= 64'h0;
    else if (clkEn) expCnt_ff <= (expCnt_ff + 64'(incOf(ctrl_ff, cEv, hEv))) & ((64'h1 << CW) - 1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failCount == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failCount++;
      results();
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // A status read while the source runs lets the checker see live tracker bits.
  task automatic traffic(input int n);
    run <= 1'b1;
    apb(0, OFS_STATUS, 0);
    repeat (n) begin
      @(posedge ref_clk);
      clkEn <= ($urandom_range(7) != 0);
    end
    run <= 1'b0;
    badFill <= 1'b0;
    clkEn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    {rst_n, run, badFill, err, failCount, nChecks} = '0;
    clkEn = 1'b1;
    req = '0;
    void'($urandom(86));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(0, OFS_CTRL, 0);
    check(q, 32'h0);
    apb(0, OFS_STATUS, 0);
    check(q, 32'h0);
    // Table rows carry the event code in the upper byte and the unit mask below it.
    for (i = 0; i < 36; i++) begin
      w = (i < 28) ? {15'h0, 1'b1, tbl[i][7:0], tbl[i][15:8]}
        : {15'h0, 1'($urandom), 8'($urandom), tbl[$urandom_range(27)][15:8]};
      apb(1, OFS_CTRL, w | 32'h00020000);
      traffic(20 + $urandom_range(40));
      apb(0, OFS_CTRL, 0);
      check(q, w);
      apb(0, OFS_CNT_LO, 0);
      check(q, expCnt_ff[31:0]);
      apb(0, OFS_CNT_HI, 0);
      check(q, expCnt_ff[63:32]);
      known = w[7:0] inside {EVC_FILL, EVC_VICTIM, EVC_HOME_REQ, EVC_TRK_FULL,
                             EVC_TRK_BUSY};
      apb(0, OFS_STATUS, 0);
      check(q, {31'h0, known});
    end
    apb(1, OFS_CNT_LO, 32'hFFFFFFFF);
    check({31'h0, err}, 32'h0);
    apb(0, OFS_CNT_LO, 0);
    check(q, expCnt_ff[31:0]);
    apb(0, 12'h010, 0);
    check({31'h0, err}, 32'h1);
    apb(1, OFS_CTRL, 32'h00030F0A);
    badFill <= 1'b1;
    traffic(20);
    apb(0, OFS_CNT_LO, 0);
    check(q, 32'h0);
    apb(0, OFS_STATUS, 0);
    check(q, 32'h3);
    apb(1, OFS_STATUS, 32'h2);
    apb(0, OFS_STATUS, 0);
    check(q, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(0, OFS_CTRL, 0);
    check(q, 32'h0);
    apb(0, OFS_STATUS, 0);
    check(q, 32'h0);
    results();
  end
endmodule
